// >>> hw/ads_top.sv
// Accessory detect status: supply, ident and both-high status and irqs.
// Assumes comparator levels arrive synchronous to the 10 MHz clock.
`timescale 1ns/1ps
module ads_top #(
  parameter int VALID_RISE_CYC = ads_pkg::VALID_RISE_CYC,
  parameter int VALID_FALL_CYC = ads_pkg::VALID_FALL_CYC,
  parameter int BOTH_HIGH_CYC = ads_pkg::BOTH_HIGH_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic supply_valid_cmp,
  input wire logic supply_mid_cmp,
  input wire logic supply_low_cmp,
  input wire logic ident_above_high_cmp,
  input wire logic ident_below_low_cmp,
  input wire logic ident_factory_cmp,
  input wire logic both_high_cmp,
  input wire logic charger_detect_cmp,
  input wire logic transceiver_supply_on,
  input wire logic [ads_pkg::AW-1:0] addr,
  input wire logic [ads_pkg::DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [ads_pkg::DW-1:0] rd_data,
  output logic accessory_irq_pin,
  output logic pullup_resistor_en,
  output logic pullup_current_en,
  output logic power_path_override,
  output logic power_path_control,
  output logic both_high_charger
);
  // Address match, shared by write and read decode
  function automatic logic reg_hit(input logic [ads_pkg::AW-1:0] a,
                                   input logic [ads_pkg::AW-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // Ident priority: factory, then floating, then grounded, else mid
  function automatic ads_pkg::ads_ident_t ident_code(input logic fact,
                                                     input logic high,
                                                     input logic low);
    if (fact) begin
      ident_code = ads_pkg::ADS_ID_FACTORY;
    end else if (high) begin
      ident_code = ads_pkg::ADS_IDENT_LINE_HIGH_FLAG;
    end else if (low) begin
      ident_code = ads_pkg::ADS_IDENT_LINE_LOW_FLAG;
    end else begin
      ident_code = ads_pkg::ADS_ID_MID;
    end
  endfunction

  ads_deb_if valid_if ();
  ads_deb_if both_if ();

  logic supply_valid_level_flag_q;
  logic supply_mid_level_flag_q;
  logic supply_low_level_flag_q;
  ads_pkg::ads_ident_t ident_q;
  ads_pkg::ads_ident_t ident_d;
  logic both_high_sense_q;
  logic charger_detect_threshold_q;
  logic [ads_pkg::IRQ_N-1:0] irq_q;
  logic [ads_pkg::IRQ_N-1:0] irq_d;
  logic [ads_pkg::IRQ_N-1:0] irq_set;
  logic [ads_pkg::IRQ_N-1:0] irq_clr;
  logic [ads_pkg::DW-1:0] ctrl_q;
  logic [ads_pkg::DW-1:0] rd_data_q;
  logic accessory_irq_pin_q;
  logic pullup_resistor_en_q;
  logic pullup_current_en_q;
  logic both_high_charger_q;
  logic factory_ok;
  logic supply_chg;
  logic [ads_pkg::DW-1:0] status_word;

  // Supply valid needs a long rise settle, so it is debounced
  assign valid_if.raw = supply_valid_cmp;
  ads_debounce #(
    .RISE_CYC(VALID_RISE_CYC),
    .FALL_CYC(VALID_FALL_CYC)
  ) u_valid_deb (
    .clock(clock),
    .rst(rst),
    .d(valid_if)
  );

  // Both-high detector settles the same time in either direction
  assign both_if.raw = both_high_cmp;
  ads_debounce #(
    .RISE_CYC(BOTH_HIGH_CYC),
    .FALL_CYC(BOTH_HIGH_CYC)
  ) u_both_deb (
    .clock(clock),
    .rst(rst),
    .d(both_if)
  );

  // Supply status flags; mid and low pass with one register delay
  always_ff @(posedge clock) begin
    if (rst) begin
      supply_valid_level_flag_q <= 1'b0;
      supply_mid_level_flag_q <= 1'b0;
      supply_low_level_flag_q <= 1'b0;
    end else begin
      supply_valid_level_flag_q <= valid_if.lvl;
      supply_mid_level_flag_q <= supply_mid_cmp;
      supply_low_level_flag_q <= supply_low_cmp;
    end
  end

  // Any edge on any of the three reported levels
  assign supply_chg = valid_if.chg |
                      (supply_mid_level_flag_q != supply_mid_cmp) |
                      (supply_low_level_flag_q != supply_low_cmp);

  // Factory needs the current source unselected and the transceiver up
  assign factory_ok = ident_factory_cmp & ~ctrl_q[ads_pkg::CT_PULLUP] &
                      transceiver_supply_on;
  assign ident_d = ident_code(factory_ok, ident_above_high_cmp,
                              ident_below_low_cmp);

  // Ident status register
  always_ff @(posedge clock) begin
    if (rst) begin
      ident_q <= ads_pkg::ADS_ID_MID;
    end else begin
      ident_q <= ident_d;
    end
  end

  // Charger threshold level; masks the sense bit but not the charger copy
  always_ff @(posedge clock) begin
    if (rst) begin
      charger_detect_threshold_q <= 1'b0;
      both_high_sense_q <= 1'b0;
      both_high_charger_q <= 1'b0;
    end else begin
      charger_detect_threshold_q <= charger_detect_cmp;
      both_high_sense_q <= both_if.lvl & charger_detect_cmp;
      both_high_charger_q <= both_if.lvl;
    end
  end

  // Event sources for the sticky flags
  always_comb begin
    irq_set = '0;
    irq_set[ads_pkg::IRQ_SUPPLY] = supply_chg;
    irq_set[ads_pkg::IRQ_IDENT] = (ident_d != ident_q);
    irq_set[ads_pkg::IRQ_BOTH] = both_if.chg;
    irq_set[ads_pkg::IRQ_CHARGER] =
      (charger_detect_threshold_q != charger_detect_cmp);
  end

  // Write one to clear; a new event in the same cycle keeps its flag
  assign irq_clr = (wr_en && reg_hit(addr, ads_pkg::IRQ_OFS)) ?
                   wr_data[ads_pkg::IRQ_N-1:0] : '0;
  assign irq_d = (irq_q & ~irq_clr) | irq_set;

  // Sticky flags and the pin, both taken from the same next value
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_q <= '0;
      accessory_irq_pin_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      accessory_irq_pin_q <= |irq_d;
    end
  end

  // Control register; power path bits are only handed out
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= ads_pkg::CTRL_RST;
    end else if (wr_en && reg_hit(addr, ads_pkg::CTRL_OFS)) begin
      ctrl_q <= wr_data;
    end
  end

  // Pull-up switches; never both on, so ident is never double loaded
  always_ff @(posedge clock) begin
    if (rst) begin
      pullup_resistor_en_q <= 1'b0;
      pullup_current_en_q <= 1'b0;
    end else begin
      pullup_resistor_en_q <= ~ctrl_q[ads_pkg::CT_PULLUP];
      pullup_current_en_q <= ctrl_q[ads_pkg::CT_PULLUP];
    end
  end

  // Status word assembled from registered state only
  always_comb begin
    status_word = ads_pkg::ZERO_DATA;
    status_word[ads_pkg::ST_VALID] = supply_valid_level_flag_q;
    status_word[ads_pkg::ST_MID] = supply_mid_level_flag_q;
    status_word[ads_pkg::ST_LOW] = supply_low_level_flag_q;
    status_word[ads_pkg::ST_ID_LOW] = ident_q[0];
    status_word[ads_pkg::ST_ID_HIGH] = ident_q[1];
    status_word[ads_pkg::ST_BOTH] = both_high_sense_q;
  end

  // Read data stands for one cycle only; unmapped reads give zero
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_q <= ads_pkg::ZERO_DATA;
    end else if (!rd_en) begin
      rd_data_q <= ads_pkg::ZERO_DATA;
    end else if (reg_hit(addr, ads_pkg::STATUS_OFS)) begin
      rd_data_q <= status_word;
    end else if (reg_hit(addr, ads_pkg::IRQ_OFS)) begin
      rd_data_q <= {{(ads_pkg::DW-ads_pkg::IRQ_N){1'b0}}, irq_q};
    end else if (reg_hit(addr, ads_pkg::CTRL_OFS)) begin
      rd_data_q <= ctrl_q;
    end else begin
      rd_data_q <= ads_pkg::ZERO_DATA;
    end
  end

  assign rd_data = rd_data_q;
  assign accessory_irq_pin = accessory_irq_pin_q;
  assign pullup_resistor_en = pullup_resistor_en_q;
  assign pullup_current_en = pullup_current_en_q;
  // Software owns power routing so factory entry cannot disturb it
  assign power_path_override = ctrl_q[ads_pkg::CT_PP_OVR];
  assign power_path_control = ctrl_q[ads_pkg::CT_PP_CTL];
  assign both_high_charger = both_high_charger_q;

  // Checks on the design's own outputs
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_ident_gnd_held;
    (ident_below_low_cmp && !ident_above_high_cmp &&
     !ident_factory_cmp)[*2];
  endsequence

  sequence s_irq_untouched;
    !(wr_en && reg_hit(addr, ads_pkg::IRQ_OFS));
  endsequence

  a_low_level_follow: assert property (
    ##1 supply_low_level_flag_q == $past(supply_low_cmp))
    else $error("low level flag does not follow comparator");

  a_supply_edge_irq: assert property (
    $changed(supply_low_cmp) |=> irq_q[ads_pkg::IRQ_SUPPLY])
    else $error("supply edge did not set supply irq");

  a_mid_turn_on: assert property (
    $rose(supply_mid_cmp) |-> ##[1:2] supply_mid_level_flag_q)
    else $error("mid flag late after supply rise");

  a_ident_gnd_code: assert property (
    s_ident_gnd_held |-> ident_q == ads_pkg::ADS_IDENT_LINE_LOW_FLAG)
    else $error("grounded ident not coded 01");

  a_ident_change_irq: assert property (
    $changed(ident_q) |-> irq_q[ads_pkg::IRQ_IDENT])
    else $error("ident change without ident irq");

  a_factory_needs_xcvr: assert property (
    ident_q == ads_pkg::ADS_ID_FACTORY |-> $past(transceiver_supply_on))
    else $error("factory coded while transceiver off");

  a_pin_or_flags: assert property (
    accessory_irq_pin == (|irq_q))
    else $error("irq pin differs from OR of flags");

  a_pullup_write: assert property (
    wr_en && reg_hit(addr, ads_pkg::CTRL_OFS) |=> ##1
    pullup_current_en == $past(wr_data[ads_pkg::CT_PULLUP], 2) &&
    pullup_resistor_en != pullup_current_en)
    else $error("pull-up select not applied");

  a_factory_blocked: assert property (
    $past(ctrl_q[ads_pkg::CT_PULLUP]) |->
    ident_q != ads_pkg::ADS_ID_FACTORY)
    else $error("factory coded with current source pull-up");

  a_both_sense_mask: assert property (
    !$past(charger_detect_cmp) |-> !both_high_sense_q &&
    both_high_charger_q == $past(both_if.lvl))
    else $error("both-high sense not masked or copy disturbed");

  a_both_edge_irq: assert property (
    both_if.chg |=> irq_q[ads_pkg::IRQ_BOTH])
    else $error("both-high edge did not set irq");

  a_irq_sticky: assert property (
    irq_q[ads_pkg::IRQ_CHARGER] ##0 s_irq_untouched |=>
    irq_q[ads_pkg::IRQ_CHARGER])
    else $error("charger irq dropped without clear");

  a_charger_edge_irq: assert property (
    $changed(charger_detect_cmp) |=> irq_q[ads_pkg::IRQ_CHARGER])
    else $error("charger edge did not set charger irq");

  a_both_sense_follow: assert property (
    $past(charger_detect_cmp) |-> both_high_sense_q == $past(both_if.lvl))
    else $error("both-high sense does not follow detector");
endmodule

// >>> hw/ads_pkg.sv
// Constants shared by the accessory detect status block.
// Assumes a single 10 MHz clock and a byte-wide register port.
package ads_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam real VALID_RISE_MS = 15.0;
  localparam real VALID_FALL_MS = 0.5;
  localparam real BOTH_HIGH_MS = 1.0;
  localparam int VALID_RISE_CYC = int'(VALID_RISE_MS * 1.0E6 / CLK_PERIOD_NS);
  localparam int VALID_FALL_CYC = int'(VALID_FALL_MS * 1.0E6 / CLK_PERIOD_NS);
  localparam int BOTH_HIGH_CYC = int'(BOTH_HIGH_MS * 1.0E6 / CLK_PERIOD_NS);
  localparam int DEB_W = 18;
  localparam int AW = 8;
  localparam int DW = 8;
  // Register offsets
  localparam logic [AW-1:0] STATUS_OFS = 8'h00;
  localparam logic [AW-1:0] IRQ_OFS = 8'h01;
  localparam logic [AW-1:0] CTRL_OFS = 8'h02;
  // Status fields
  localparam int ST_VALID = 0;
  localparam int ST_MID = 1;
  localparam int ST_LOW = 2;
  localparam int ST_ID_LOW = 3;
  localparam int ST_ID_HIGH = 4;
  localparam int ST_BOTH = 5;
  // Irq flag fields, write one to clear
  localparam int IRQ_SUPPLY = 0;
  localparam int IRQ_IDENT = 1;
  localparam int IRQ_BOTH = 2;
  localparam int IRQ_CHARGER = 3;
  localparam int IRQ_N = 4;
  // Control fields
  localparam int CT_PULLUP = 0;
  localparam int CT_PP_OVR = 1;
  localparam int CT_PP_CTL = 2;
  localparam logic [DW-1:0] CTRL_RST = 8'h00;
  localparam logic [DW-1:0] ZERO_DATA = 8'h00;
  // Ident codes, high flag then low flag
  typedef enum logic [1:0] {
    ADS_ID_MID = 2'h0,
    ADS_IDENT_LINE_LOW_FLAG = 2'h1,
    ADS_IDENT_LINE_HIGH_FLAG = 2'h2,
    ADS_ID_FACTORY = 2'h3
  } ads_ident_t;
endpackage

// >>> hw/ads_deb_if.sv
// Link between the top module and one debouncer.
// Assumes both ends share the block clock.
`timescale 1ns/1ps
interface ads_deb_if;
  logic raw;
  logic lvl;
  logic chg;
  modport src (output raw, input lvl, input chg);
  modport deb (input raw, output lvl, output chg);
endinterface

// >>> hw/ads_debounce.sv
// Two-way debouncer with separate rise and fall settle times.
// Assumes raw is already synchronous to clock.
`timescale 1ns/1ps
module ads_debounce #(
  parameter int RISE_CYC = 16,
  parameter int FALL_CYC = 16
) (
  input wire logic clock,
  input wire logic rst,
  ads_deb_if.deb d
);
  logic [ads_pkg::DEB_W-1:0] cnt_q;
  logic [ads_pkg::DEB_W-1:0] target;
  logic lvl_q;
  logic chg_q;
  localparam int W = ads_pkg::DEB_W;

  // Settle time depends on the direction of the pending change
  assign target = lvl_q ? W'(FALL_CYC - 1) :
                          W'(RISE_CYC - 1);

  // Any glitch back to the old level restarts the wait
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_q <= '0;
      lvl_q <= 1'b0;
      chg_q <= 1'b0;
    end else if (d.raw == lvl_q) begin
      cnt_q <= '0;
      chg_q <= 1'b0;
    end else if (cnt_q == target) begin
      cnt_q <= '0;
      lvl_q <= d.raw;
      chg_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      chg_q <= 1'b0;
    end
  end

  assign d.lvl = lvl_q;
  assign d.chg = chg_q;

  a_deb_settle: assert property (@(posedge clock) disable iff (rst)
    $changed(lvl_q) |-> $past(cnt_q) == $past(target))
    else $error("debounced level moved before settle time");
endmodule

// >>> bench/ads_partner.sv
// Far side model: bus supply, ident line and data lines as levels.
// Assumes the bench sets the levels just after a rising clock edge.
`timescale 1ns/1ps
module ads_partner #(
  parameter int VC_MV = 2775,
  parameter int CHG_MV = 3500
) (
  input wire logic clock,
  input var int vbus_mv,
  input var int id_mv,
  input wire logic lines_high,
  output logic valid_c,
  output logic mid_c,
  output logic low_c,
  output logic idh_c,
  output logic idl_c,
  output logic idf_c,
  output logic both_c,
  output logic chg_c
);
  // Comparators settle one cycle after the level moves
  always_ff @(posedge clock) begin
    valid_c <= vbus_mv > 4400;
    mid_c <= vbus_mv > 2000;
    low_c <= vbus_mv > 800;
    chg_c <= vbus_mv > CHG_MV;
    idh_c <= id_mv * 100 > VC_MV * 89;
    idl_c <= id_mv * 100 < VC_MV * 12;
    idf_c <= id_mv > 3300;
    both_c <= lines_high;
  end
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the accessory detect status block.
// Assumes short debounce counts and a partner model on the inputs.
`timescale 1ns/1ps
module testbench;
  logic clock, rst, tx_on, lines_high, wr_en, rd_en;
  logic [7:0] addr, wr_data, rd_data, st;
  logic pin, res_en, cur_en, pp_ovr, pp_ctl, bh_chg;
  logic v_c, m_c, l_c, ih_c, il_c, if_c, b_c, c_c;
  int vbus_mv, id_mv, error_cnt, n_checks;

  // Short counts keep the run brief
  ads_top #(.VALID_RISE_CYC(20), .VALID_FALL_CYC(5), .BOTH_HIGH_CYC(8)) i_dut (
    .clock(clock), .rst(rst), .supply_valid_cmp(v_c), .supply_mid_cmp(m_c),
    .supply_low_cmp(l_c), .ident_above_high_cmp(ih_c),
    .ident_below_low_cmp(il_c), .ident_factory_cmp(if_c),
    .both_high_cmp(b_c), .charger_detect_cmp(c_c),
    .transceiver_supply_on(tx_on), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .accessory_irq_pin(pin), .pullup_resistor_en(res_en),
    .pullup_current_en(cur_en), .power_path_override(pp_ovr),
    .power_path_control(pp_ctl), .both_high_charger(bh_chg));

  ads_partner i_far (
    .clock(clock), .vbus_mv(vbus_mv), .id_mv(id_mv),
    .lines_high(lines_high), .valid_c(v_c), .mid_c(m_c), .low_c(l_c),
    .idh_c(ih_c), .idl_c(il_c), .idf_c(if_c), .both_c(b_c), .chg_c(c_c));

  // Compare and count
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clock);
  endtask

  // Waits, then lands mid-cycle so outputs are settled
  task automatic settle(int n);
    cyc(n);
    @(negedge clock);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    st = rd_data;
    chk(st, exp);
  endtask

  // Read irq flags, then clear them all
  task automatic irq_clr(logic [7:0] q);
    rd_chk(ads_pkg::IRQ_OFS, q);
    wr(ads_pkg::IRQ_OFS, 8'hFF);
  endtask

  // One level change: status, flags, pin raised and dropped
  task automatic step(int v, int i, logic [7:0] s, logic [7:0] q);
    cyc(1);
    vbus_mv <= v;
    id_mv <= i;
    settle(3);
    chk({7'h0, pin}, 8'h01);
    rd_chk(ads_pkg::STATUS_OFS, s);
    irq_clr(q);
    settle(1);
    chk({7'h0, pin}, 8'h00);
  endtask

  task automatic t_reset();
    settle(3);
    chk({6'h0, res_en, cur_en}, 8'h02);
    chk({7'h0, pin}, 8'h00);
    rd_chk(ads_pkg::CTRL_OFS, ads_pkg::CTRL_RST);
    rd_chk(ads_pkg::IRQ_OFS, 8'h00);
    rd_chk(8'h7F, 8'h00);
    wr(ads_pkg::STATUS_OFS, 8'hFF);
    rd_chk(ads_pkg::STATUS_OFS, 8'h00);
  endtask

  task automatic t_supply();
    step(1000, 1000, 8'h04, 8'h01);
    step(2500, 1000, 8'h06, 8'h01);
    step(1000, 1000, 8'h04, 8'h01);
    step(0, 1000, 8'h00, 8'h01);
  endtask

  // Valid level must hold before it is reported; charger edges ride along
  task automatic t_valid();
    cyc(1);
    vbus_mv <= 5000;
    settle(4);
    rd_chk(ads_pkg::STATUS_OFS, 8'h06);
    settle(25);
    rd_chk(ads_pkg::STATUS_OFS, 8'h07);
    irq_clr(8'h09);
    cyc(1);
    vbus_mv <= 3000;
    settle(12);
    rd_chk(ads_pkg::STATUS_OFS, 8'h06);
    irq_clr(8'h09);
    step(0, 1000, 8'h00, 8'h01);
  endtask

  task automatic t_ident();
    step(0, 0, 8'h08, 8'h02);
    step(0, 2700, 8'h10, 8'h02);
    step(0, 3500, 8'h18, 8'h02);
    step(0, 1000, 8'h00, 8'h02);
  endtask

  // Current source selected: open line must not read as factory
  task automatic t_pullup();
    wr(ads_pkg::CTRL_OFS, 8'h01);
    settle(2);
    chk({6'h0, res_en, cur_en}, 8'h01);
    step(0, 3500, 8'h10, 8'h02);
    step(0, 1000, 8'h00, 8'h02);
    wr(ads_pkg::CTRL_OFS, 8'h00);
    settle(2);
    chk({6'h0, res_en, cur_en}, 8'h02);
  endtask

  task automatic t_xcvr_off();
    cyc(1);
    tx_on <= 1'b0;
    step(0, 0, 8'h08, 8'h02);
    step(4000, 3500, 8'h16, 8'h0B);
    step(0, 1000, 8'h00, 8'h0B);
    cyc(1);
    tx_on <= 1'b1;
  endtask

  task automatic t_both();
    cyc(1);
    vbus_mv <= 5000;
    settle(30);
    irq_clr(8'h09);
    cyc(1);
    lines_high <= 1'b1;
    settle(4);
    rd_chk(ads_pkg::STATUS_OFS, 8'h07);
    settle(15);
    rd_chk(ads_pkg::STATUS_OFS, 8'h27);
    chk({7'h0, bh_chg}, 8'h01);
    irq_clr(8'h04);
    cyc(1);
    vbus_mv <= 3000;
    settle(15);
    rd_chk(ads_pkg::STATUS_OFS, 8'h06);
    chk({7'h0, bh_chg}, 8'h01);
    wr(ads_pkg::IRQ_OFS, 8'hFF);
    cyc(1);
    lines_high <= 1'b0;
    settle(15);
    chk({7'h0, bh_chg}, 8'h00);
    rd_chk(ads_pkg::IRQ_OFS, 8'h04);
  endtask

  // Software owns the power path; the outputs follow the control bits
  task automatic t_power_path();
    wr(ads_pkg::CTRL_OFS, 8'h06);
    settle(1);
    chk({6'h0, pp_ovr, pp_ctl}, 8'h03);
    rd_chk(ads_pkg::CTRL_OFS, 8'h06);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Hang guard, well past the expected run length
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    tx_on = 1'b1;
    lines_high = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    vbus_mv = 0;
    id_mv = 1000;
    error_cnt = 0;
    n_checks = 0;
    cyc(5);
    rst <= 1'b0;
    t_reset();
    t_supply();
    t_valid();
    t_ident();
    t_pullup();
    t_xcvr_off();
    t_both();
    t_power_path();
    tally_and_finish();
  end
endmodule
